// ==== hsq_axis_homing_block.sv ====
// Axis homing sequencer with a Wishbone register slave and a service-channel request port
// Contract
// - One start pulse begins one homing cycle; a held request never restarts it.
// - Option flag bit 0 set sends the option word first, clear skips it.
// - Writes go option word 147, reference value 52, then start 148.
// - Then read 148 started, 403 finished, and 47 position.
// - Step output shows current step, returns to 0 on completion.
// - Signed 32-bit reference value is the reference-position payload.
// - Done rises when the whole cycle incl. position read succeeds.
// - Error code zero without error, nonzero on failure; fail goes with it.
// - Slave error code nonzero only when error code equals 128.
// - On completion a signed 32-bit result shows the position read from parameter 47.
// - All parameter transfers go over the service channel only.
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module hsq_axis_homing_block
  import hsq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic sc_req_o,
  output hsq_sc_cmd_s sc_cmd_o,
  input wire logic sc_done_i,
  input wire logic [15:0] sc_err_i,
  input wire logic [15:0] sc_slave_error_code_i,
  input wire logic [31:0] sc_rdata_i,
  output logic done_o,
  output logic fail_o,
  output logic [2:0] step_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [16:0] step_target(input logic [2:0] step);
    logic [16:0] r;
    r = {1'b0, 16'h0000};
    case (step)
      HSQ_STEP_OPTION: r = {1'b1, HSQ_IDN_OPTION};
      HSQ_STEP_REFPOS: r = {1'b1, HSQ_IDN_REFPOS};
      HSQ_STEP_START: r = {1'b1, HSQ_IDN_START};
      HSQ_STEP_STARTED: r = {1'b0, HSQ_IDN_START};
      HSQ_STEP_REFDONE: r = {1'b0, HSQ_IDN_REFDONE};
      HSQ_STEP_POSITION: r = {1'b0, HSQ_IDN_POSITION};
      default: r = {1'b0, 16'h0000};
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  hsq_locator_s locator_q;
  logic signed [31:0] refval_q;
  logic [15:0] optword_q;
  logic [15:0] optflags_q;
  logic [15:0] err_q;
  logic [15:0] slave_error_code_q;
  logic signed [31:0] result_q;
  logic done_q;
  logic fail_q;
  logic [2:0] step_q;
  logic start_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic req_q;
  hsq_sc_cmd_s cmd_q;
  hsq_state_e state_q;
  logic wb_take;
  logic wb_wr;
  logic sc_ok;
  logic [31:0] status_w;
  logic [16:0] tgt_w;

  assign wb_take = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr = wb_take && wb_we_i;
  assign sc_ok = (state_q == HSQ_ST_WAIT) && sc_done_i && (sc_err_i == 16'h0000);
  assign status_w = {21'h00_0000, step_q, 5'h00, (state_q != HSQ_ST_IDLE), fail_q, done_q};
  assign tgt_w = step_target(step_q);

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_take;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= HSQ_RST_WORD;
    end else if (wb_take) begin
      case (wb_adr_i)
        HSQ_OFS_LOCATOR: rdata_q <= {8'h00, locator_q};
        HSQ_OFS_REFVAL: rdata_q <= refval_q;
        HSQ_OFS_OPTWORD: rdata_q <= {16'h0000, optword_q};
        HSQ_OFS_OPTFLAGS: rdata_q <= {16'h0000, optflags_q};
        HSQ_OFS_STATUS: rdata_q <= status_w;
        HSQ_OFS_ERROR: rdata_q <= {slave_error_code_q, err_q};
        HSQ_OFS_RESULT: rdata_q <= result_q;
        default: rdata_q <= HSQ_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locator_q <= '0;
      refval_q <= HSQ_RST_WORD;
      optword_q <= 16'h0000;
      optflags_q <= 16'h0000;
    end else if (wb_wr) begin
      case (wb_adr_i)
        HSQ_OFS_LOCATOR: locator_q <= hsq_locator_s'(24'(merge_bytes({8'h00, locator_q}, wb_dat_i, wb_sel_i)));
        HSQ_OFS_REFVAL: refval_q <= merge_bytes(refval_q, wb_dat_i, wb_sel_i);
        HSQ_OFS_OPTWORD: optword_q <= 16'(merge_bytes({16'h0000, optword_q}, wb_dat_i, wb_sel_i));
        HSQ_OFS_OPTFLAGS: optflags_q <= 16'(merge_bytes({16'h0000, optflags_q}, wb_dat_i, wb_sel_i));
        default: optflags_q <= optflags_q;
      endcase
    end
  end

  // Start strobe lasts one cycle per write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wb_wr && (wb_adr_i == HSQ_OFS_CTRL) && wb_sel_i[0] && wb_dat_i[HSQ_CTRL_START_BIT];
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= HSQ_ST_IDLE;
      step_q <= HSQ_STEP_NONE;
    end else begin
      case (state_q)
        HSQ_ST_IDLE: begin
          if (start_q) begin
            state_q <= HSQ_ST_ISSUE;
            step_q <= optflags_q[HSQ_OPT_SEND147_BIT] ? HSQ_STEP_OPTION : HSQ_STEP_REFPOS;
          end
        end
        HSQ_ST_ISSUE: begin
          state_q <= HSQ_ST_WAIT;
        end
        HSQ_ST_WAIT: begin
          if (sc_done_i) begin
            if (sc_err_i != 16'h0000) begin
              state_q <= HSQ_ST_IDLE;
            end else if (step_q == HSQ_STEP_POSITION) begin
              state_q <= HSQ_ST_IDLE;
              step_q <= HSQ_STEP_NONE;
            end else if (step_q == HSQ_STEP_REFDONE && !sc_rdata_i[HSQ_REFDONE_BIT]) begin
              state_q <= HSQ_ST_ISSUE;
            end else begin
              state_q <= HSQ_ST_ISSUE;
              step_q <= step_q + 3'h1;
            end
          end
        end
        default: begin
          state_q <= HSQ_ST_IDLE;
          step_q <= HSQ_STEP_NONE;
        end
      endcase
    end
  end

  // Service-channel request, one pulse per transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      req_q <= (state_q == HSQ_ST_ISSUE);
      if (state_q == HSQ_ST_ISSUE) begin
        cmd_q.locator <= locator_q;
        cmd_q.write <= tgt_w[16];
        cmd_q.idn <= tgt_w[15:0];
        case (step_q)
          HSQ_STEP_OPTION: cmd_q.data <= {16'h0000, optword_q};
          HSQ_STEP_REFPOS: cmd_q.data <= refval_q;
          HSQ_STEP_START: cmd_q.data <= HSQ_START_CMD_VALUE;
          default: cmd_q.data <= HSQ_RST_WORD;
        endcase
      end
    end
  end

  // Outcome
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      err_q <= 16'h0000;
      slave_error_code_q <= 16'h0000;
      result_q <= HSQ_RST_WORD;
    end else if (state_q == HSQ_ST_IDLE && start_q) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      err_q <= 16'h0000;
      slave_error_code_q <= 16'h0000;
    end else if (state_q == HSQ_ST_WAIT && sc_done_i) begin
      if (sc_err_i != 16'h0000) begin
        fail_q <= 1'b1;
        err_q <= sc_err_i;
        slave_error_code_q <= (sc_err_i == HSQ_SLAVE_ERR_CODE) ? sc_slave_error_code_i : 16'h0000;
      end else if (step_q == HSQ_STEP_POSITION) begin
        done_q <= 1'b1;
        result_q <= sc_rdata_i;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign sc_req_o = req_q;
  assign sc_cmd_o = cmd_q;
  assign done_o = done_q;
  assign fail_o = fail_q;
  assign step_o = step_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_option: assert property (start_q && state_q == HSQ_ST_IDLE && optflags_q[0]
                                   |=> step_q == 3'h1 ##1 sc_req_o && sc_cmd_o.idn == 16'h0093)
    else $error("option step not started");
  a_start_skip: assert property (start_q && state_q == HSQ_ST_IDLE && !optflags_q[0]
                                 |=> step_q == 3'h2)
    else $error("option step not skipped");
  a_busy_norestart: assert property (start_q && state_q == HSQ_ST_WAIT && !sc_done_i
                                     |=> state_q == HSQ_ST_WAIT && $stable(step_q))
    else $error("busy cycle restarted");
  a_refpos_payload: assert property (sc_req_o && step_q == 3'h2
                                     |-> sc_cmd_o.write && sc_cmd_o.idn == 16'h0034 && sc_cmd_o.data == refval_q)
    else $error("reference position write wrong");
  a_start_write: assert property (sc_req_o && step_q == 3'h3 |-> sc_cmd_o.write && sc_cmd_o.idn == 16'h0094)
    else $error("start command wrong");
  a_read_steps: assert property (sc_req_o && step_q >= 3'h4 |-> !sc_cmd_o.write)
    else $error("read step issued as write");
  a_poll_repeat: assert property (sc_ok && step_q == 3'h5 && !sc_rdata_i[0]
                                  |=> state_q == HSQ_ST_ISSUE && step_q == 3'h5 ##1 sc_req_o)
    else $error("unfinished homing not polled again");
  a_req_pulse: assert property (sc_req_o |=> !sc_req_o)
    else $error("request longer than one cycle");
  a_fail_abort: assert property (state_q == HSQ_ST_WAIT && sc_done_i && sc_err_i != 16'h0000
                                 |=> fail_q && err_q != 16'h0000 && state_q == HSQ_ST_IDLE
                                     && step_q == $past(step_q))
    else $error("transfer error not reported");
  a_slave_error_code_gate: assert property (err_q != 16'h0080 |-> slave_error_code_q == 16'h0000)
    else $error("slave error without code 128");
  a_done_result: assert property (sc_ok && step_q == 3'h6
                                  |=> done_q && step_q == 3'h0 && result_q == $past(sc_rdata_i))
    else $error("completion not reported");
  a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");

endmodule // hsq_axis_homing_block

// ==== hsq_drive_model.sv ====
// Service-channel drive model answering the sequencer transfers
`timescale 1ns/10ps
module hsq_drive_model
  import hsq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic sc_req_i,
  input wire hsq_sc_cmd_s sc_cmd_i,
  input wire logic [3:0] lat_i,
  input wire logic [3:0] fail_at_i,
  input wire logic [15:0] err_code_i,
  input wire logic [15:0] slave_error_code_i,
  input wire logic [1:0] polls_i,
  input wire logic [31:0] pos_i,
  output logic sc_done_o,
  output logic [15:0] sc_err_o,
  output logic [15:0] sc_slave_error_code_o,
  output logic [31:0] sc_rdata_o
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [3:0] num_q;
  logic [1:0] poll_q;
  logic [15:0] idn_q;
  logic bad;
  assign bad = (fail_at_i != 4'h0) && (num_q == fail_at_i);
  // ----------------------------------------
  // Answer after a chosen delay
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    sc_done_o <= 1'b0;
    sc_err_o <= ~sc_err_o;
    sc_slave_error_code_o <= ~sc_slave_error_code_o;
    sc_rdata_o <= ~sc_rdata_o;
    if (rst_i) begin
      sc_err_o <= 16'h0000;
      sc_slave_error_code_o <= 16'h0000;
      sc_rdata_o <= 32'h0000_0000;
    end
    if (rst_i || clr_i) begin
      busy_q <= 1'b0;
      num_q <= 4'h0;
      poll_q <= 2'h0;
    end else if (sc_req_i) begin
      busy_q <= 1'b1;
      cnt_q <= lat_i;
      num_q <= num_q + 4'h1;
      idn_q <= sc_cmd_i.idn;
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      sc_done_o <= 1'b1;
      sc_err_o <= bad ? err_code_i : 16'h0000;
      sc_slave_error_code_o <= bad ? slave_error_code_i : 16'h0000;
      sc_rdata_o <= pos_i;
      if (idn_q == HSQ_IDN_REFDONE) begin
        sc_rdata_o <= {31'h0000_0000, poll_q == polls_i};
        poll_q <= poll_q + 2'h1;
      end
    end
  end
endmodule // hsq_drive_model

// ==== hsq_pkg.sv ====
// Package for the axis homing sequencer: register map, step codes, parameter numbers, carriers
package hsq_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] HSQ_OFS_CTRL = 5'h00;
  localparam logic [4:0] HSQ_OFS_LOCATOR = 5'h04;
  localparam logic [4:0] HSQ_OFS_REFVAL = 5'h08;
  localparam logic [4:0] HSQ_OFS_OPTWORD = 5'h0C;
  localparam logic [4:0] HSQ_OFS_OPTFLAGS = 5'h10;
  localparam logic [4:0] HSQ_OFS_STATUS = 5'h14;
  localparam logic [4:0] HSQ_OFS_ERROR = 5'h18;
  localparam logic [4:0] HSQ_OFS_RESULT = 5'h1C;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int HSQ_CTRL_START_BIT = 0;
  localparam int HSQ_OPT_SEND147_BIT = 0;
  localparam int HSQ_STAT_DONE_BIT = 0;
  localparam int HSQ_STAT_FAIL_BIT = 1;
  localparam int HSQ_STAT_BUSY_BIT = 2;
  localparam int HSQ_STAT_STEP_LSB = 8;
  localparam int HSQ_REFDONE_BIT = 0;
  localparam logic [15:0] HSQ_SLAVE_ERR_CODE = 16'h0080;
  localparam logic [31:0] HSQ_START_CMD_VALUE = 32'h0000_0003;
  localparam logic [31:0] HSQ_RST_WORD = 32'h0000_0000;

  // ----------------------------------------
  // Step codes
  // ----------------------------------------
  localparam logic [2:0] HSQ_STEP_NONE = 3'h0;
  localparam logic [2:0] HSQ_STEP_OPTION = 3'h1;
  localparam logic [2:0] HSQ_STEP_REFPOS = 3'h2;
  localparam logic [2:0] HSQ_STEP_START = 3'h3;
  localparam logic [2:0] HSQ_STEP_STARTED = 3'h4;
  localparam logic [2:0] HSQ_STEP_REFDONE = 3'h5;
  localparam logic [2:0] HSQ_STEP_POSITION = 3'h6;

  // ----------------------------------------
  // Parameter numbers
  // ----------------------------------------
  localparam logic [15:0] HSQ_IDN_OPTION = 16'h0093;
  localparam logic [15:0] HSQ_IDN_REFPOS = 16'h0034;
  localparam logic [15:0] HSQ_IDN_START = 16'h0094;
  localparam logic [15:0] HSQ_IDN_REFDONE = 16'h0193;
  localparam logic [15:0] HSQ_IDN_POSITION = 16'h002F;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] slave;
    logic [7:0] ring;
    logic [7:0] slot;
  } hsq_locator_s;

  typedef struct packed {
    hsq_locator_s locator;
    logic write;
    logic [15:0] idn;
    logic [31:0] data;
  } hsq_sc_cmd_s;

  typedef enum logic [1:0] {
    HSQ_ST_IDLE,
    HSQ_ST_ISSUE,
    HSQ_ST_WAIT
  } hsq_state_e;

endpackage

// ==== hsq_testbench.sv ====
// Self-checking bench for the axis homing sequencer
`timescale 1ns/10ps
module testbench
  import hsq_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0000_0000, rd, rdat, pos = 32'h0000_0000;
  logic ack, req, dn, done, fail;
  logic [15:0] err, slave_error_code, ecode = 16'h0000, sval = 16'h0000;
  logic [3:0] lat = 4'h0, fat = 4'h0;
  logic [1:0] polls = 2'h0;
  logic [3:0] sel = 4'hF;
  logic [2:0] step;
  hsq_sc_cmd_s cmd;
  hsq_sc_cmd_s seen_q[$];
  logic [2:0] sstep_q[$], e_stp[$];
  logic [15:0] e_idn[$];
  logic e_wr[$];
  logic [31:0] e_dat[$];
  int seed = 11;
  int mismatches = 0;
  int check_count = 0;
  int fail_tab[8] = '{0, 3, 3, 1, 1, 5, 0, 7};
  initial forever #12.5 clk_i = ~clk_i;
  hsq_axis_homing_block dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .sc_req_o(req),
    .sc_cmd_o(cmd), .sc_done_i(dn), .sc_err_i(err), .sc_slave_error_code_i(slave_error_code), .sc_rdata_i(rdat), .done_o(done),
    .fail_o(fail), .step_o(step));
  hsq_drive_model drv (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr), .sc_req_i(req), .sc_cmd_i(cmd),
    .lat_i(lat), .fail_at_i(fat), .err_code_i(ecode), .slave_error_code_i(sval), .polls_i(polls), .pos_i(pos),
    .sc_done_o(dn), .sc_err_o(err), .sc_slave_error_code_o(slave_error_code), .sc_rdata_o(rdat));
  always @(posedge clk_i) begin
    if (req === 1'b1) begin
      seen_q.push_back(cmd);
      sstep_q.push_back(step);
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rd;
    chk("wb_ack", ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic add(input logic [15:0] i, input logic w, input logic [31:0] d, input logic [2:0] s);
    e_idn.push_back(i);
    e_wr.push_back(w);
    e_dat.push_back(d);
    e_stp.push_back(s);
  endtask
  task automatic run(input int i);
    logic [31:0] loc, rv, ow, q;
    logic [2:0] fs;
    int n;
    loc = $random(seed) & 32'h00FF_FFFF;
    rv = $random(seed);
    ow = ($random(seed) & 32'h0000_FFE3) | 32'h0000_0014;
    lat <= 4'($random(seed));
    polls <= 2'(i % 3);
    fat <= 4'(fail_tab[i]);
    ecode <= i[1] ? 16'h0080 : 16'h0011;
    sval <= 16'($random(seed)) | 16'h0001;
    pos <= $random(seed);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wb(1'b1, HSQ_OFS_LOCATOR, loc, q);
    wb(1'b1, HSQ_OFS_REFVAL, rv, q);
    wb(1'b1, HSQ_OFS_OPTWORD, ow, q);
    wb(1'b1, HSQ_OFS_OPTFLAGS, ($random(seed) & 32'h0000_FFFE) | i[0], q);
    wb(1'b0, HSQ_OFS_REFVAL, 32'h0000_0000, q);
    chk("refval", q, rv);
    e_idn.delete();
    e_wr.delete();
    e_dat.delete();
    e_stp.delete();
    seen_q.delete();
    sstep_q.delete();
    if (i[0]) add(HSQ_IDN_OPTION, 1'b1, {16'h0000, ow[15:0]}, HSQ_STEP_OPTION);
    add(HSQ_IDN_REFPOS, 1'b1, rv, HSQ_STEP_REFPOS);
    add(HSQ_IDN_START, 1'b1, HSQ_START_CMD_VALUE, HSQ_STEP_START);
    add(HSQ_IDN_START, 1'b0, 0, HSQ_STEP_STARTED);
    for (n = 0; n <= i % 3; n++) add(HSQ_IDN_REFDONE, 1'b0, 0, HSQ_STEP_REFDONE);
    add(HSQ_IDN_POSITION, 1'b0, 0, HSQ_STEP_POSITION);
    fs = HSQ_STEP_NONE;
    if (fail_tab[i] != 0) begin
      fs = e_stp[fail_tab[i] - 1];
      while (e_idn.size() > fail_tab[i]) begin
        void'(e_idn.pop_back());
        void'(e_wr.pop_back());
        void'(e_dat.pop_back());
        void'(e_stp.pop_back());
      end
    end
    wb(1'b1, HSQ_OFS_CTRL, 32'h0000_0001, q);
    wb(1'b1, HSQ_OFS_CTRL, 32'h0000_0001, q);
    n = 0;
    while (done !== 1'b1 && fail !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    chk("count", seen_q.size(), e_idn.size());
    foreach (e_idn[k]) if (k < seen_q.size()) begin
      chk("idn", seen_q[k].idn, e_idn[k]);
      chk("dir", seen_q[k].write, e_wr[k]);
      if (e_wr[k]) chk("data", seen_q[k].data, e_dat[k]);
      chk("locator", seen_q[k].locator, loc[23:0]);
      chk("step", sstep_q[k], e_stp[k]);
    end
    chk("done", done, fail_tab[i] == 0);
    chk("fail", fail, fail_tab[i] != 0);
    chk("step_out", step, fs);
    wb(1'b0, HSQ_OFS_ERROR, 32'h0000_0000, q);
    chk("error", q, fail_tab[i] == 0 ? 0 : {(ecode == 16'h0080) ? sval : 16'h0000, ecode});
    wb(1'b0, HSQ_OFS_STATUS, 32'h0000_0000, q);
    chk("status", {q[10:8], q[2:0]}, {fs, 1'b0, fail_tab[i] != 0, fail_tab[i] == 0});
    if (fail_tab[i] == 0) begin
      wb(1'b0, HSQ_OFS_RESULT, 32'h0000_0000, q);
      chk("result", q, pos);
    end
    $display("test %0d ended", i);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      wb(1'b0, 5'(k * 4), 32'h0000_0000, q);
      chk("reset_value", q, HSQ_RST_WORD);
    end
    sel <= 4'hA;
    wb(1'b1, HSQ_OFS_REFVAL, 32'hA5A5_A5A5, q);
    wb(1'b1, HSQ_OFS_CTRL, 32'h0000_0001, q);
    sel <= 4'hF;
    wb(1'b0, HSQ_OFS_REFVAL, 32'h0000_0000, q);
    chk("sel_merge", q, 32'hA500_A500);
    wb(1'b0, HSQ_OFS_STATUS, 32'h0000_0000, q);
    chk("sel_start", q, HSQ_RST_WORD);
    $display("reset test ended");
    for (int k = 0; k < 8; k++) run(k);
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end
endmodule // testbench
